// [rtl/brls_exec.sv]
// Execute unit for immediate branches, returns, barrier, loads and stores
`timescale 1ns/1ps
`default_nettype none
module brls_exec
  import brls_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Instruction issue
  input  wire logic        instrValid,
  input  wire logic [31:0] instr,
  input  wire logic [31:0] pc,
  input  wire logic [31:0] opA,
  input  wire logic [31:0] opB,
  input  wire logic [31:0] opD,
  output logic             busy,
  output logic             done,
  output logic [31:0]      pcNext,
  output logic             taken,
  output logic             delaySlot,
  output logic             rdWe,
  output logic [4:0]       rdIdx,
  output logic [31:0]      rdData,
  output logic             illegal,
  output logic             unalignedFault,
  output logic             irqHold,
  // Events from the surrounding core
  input  wire logic        irqTaken,
  input  wire logic        excTaken,
  input  wire logic [31:0] excCause,
  input  wire logic        brkTaken,
  // Data memory bus
  output logic             memReq,
  output logic             memWe,
  output logic [31:0]      memAddr,
  output logic [31:0]      memAddrHi,
  output logic [31:0]      memWdata,
  output logic [3:0]       memBe,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata,
  input  wire logic        memDrained,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWe,
  input  wire logic        regRe,
  output logic [31:0]      regRdata,
  // Status bits shown to the core
  output logic             interruptEnable,
  output logic             breakInProgress,
  output logic             exceptionEnable,
  output logic             exceptionInProgress,
  output logic             reservation
);

  typedef enum logic [1:0] {S_IDLE, S_MEM, S_BAR} brls_state_t;

  // Sign-extend, or join with a pending prefix
  function automatic logic [31:0] extImm(input logic [15:0] imm,
                                         input logic        pre,
                                         input logic [15:0] hi);
    extImm = pre ? {hi, imm} : {{16{imm[15]}}, imm};
  endfunction

  // Byte enables, big-endian lanes: offset 0 is bits 31:24
  function automatic logic [3:0] laneBe(input logic [1:0] sz, input logic [1:0] off);
    unique case (sz)
      SZ_BYTE: laneBe = 4'h8 >> off;
      SZ_HALF: laneBe = off[1] ? 4'h3 : 4'hc;
      default: laneBe = 4'hf;
    endcase
  endfunction

  // Pick the loaded item and zero-fill the upper bits
  function automatic logic [31:0] loadData(input logic [1:0]  sz,
                                           input logic [1:0]  off,
                                           input logic [31:0] d);
    logic [31:0] sh;
    sh = d >> {~off, 3'h0};
    unique case (sz)
      SZ_BYTE: loadData = {24'h000000, sh[7:0]};
      SZ_HALF: loadData = {16'h0000, (off[1] ? d[15:0] : d[31:16])};
      default: loadData = d;
    endcase
  endfunction

  brls_state_t state_r;          // Sequencer state
  logic        prefValid_r;      // Prefix waiting for its partner
  logic [15:0] prefHi_r;         // Upper immediate half from the prefix
  logic        ldPend_r;         // Outstanding access is a load
  logic        resvPend_r;       // Outstanding load is the reserving one
  logic [1:0]  szPend_r;         // Size of the outstanding access
  logic        ie_r, carry_r, bip_r, ee_r, eip_r, resv_r;
  logic [31:0] cause_r;          // Exception cause

  // Decode fields
  logic [5:0]  op;
  logic [4:0]  fD, fA;
  logic [10:0] fn;
  logic [15:0] imm;
  logic [31:0] sImm;
  assign op   = instr[31:26];
  assign fD   = instr[25:21];
  assign fA   = instr[20:16];
  assign fn   = instr[10:0];
  assign imm  = instr[15:0];
  assign sImm = extImm(imm, prefValid_r, prefHi_r);

  // Decode results
  logic        dTake, dLink, dDelay, dIll, dBar, dPrefix;
  logic        dSetIe, dSetBip, dClrBip, dRte, dMem, dLoad, dResv, dCond, dExt, dFault;
  logic [31:0] dTarget, dAddr, dWdata;
  logic [1:0]  dSz;
  logic        zero, neg;
  assign zero = (opA == 32'h0000_0000);
  assign neg  = opA[31];

  // Combinational decode of one issued instruction
  always_comb begin
    dTake   = 1'b0;
    dLink   = 1'b0;
    dDelay  = 1'b0;
    dIll    = 1'b0;
    dBar    = 1'b0;
    dPrefix = 1'b0;
    dSetIe  = 1'b0;
    dSetBip = 1'b0;
    dClrBip = 1'b0;
    dRte    = 1'b0;
    dMem    = 1'b0;
    dLoad   = 1'b0;
    dResv   = 1'b0;
    dCond   = 1'b0;
    dExt    = 1'b0;
    dSz     = SZ_WORD;
    dTarget = pc + sImm;
    dAddr   = opA + opB;
    unique case (op)
      OP_PREFIX: begin
        // Narrow prefix only
        if (fD == PREFIX_SEL && fA == PREFIX_SEL) begin
          dPrefix = 1'b1;
        end else begin
          dIll = 1'b1;
        end
      end
      OP_BCCIMM: begin
        dDelay = fD[4];
        unique case (fD[2:0])
          CC_EQ: dTake = zero;
          CC_NE: dTake = !zero;
          CC_LT: dTake = neg;
          CC_LE: dTake = neg || zero;
          CC_GT: dTake = !neg && !zero;
          CC_GE: dTake = !neg;
          default: dIll = 1'b1;
        endcase
      end
      OP_BRIMM: begin
        unique case (fA)
          BR_REL, BR_RELD: begin
            dTake  = 1'b1;
            dDelay = fA[4];
          end
          BR_RELLD: begin
            dTake  = 1'b1;
            dLink  = 1'b1;
            dDelay = 1'b1;
          end
          BR_ABS, BR_ABSD, BR_ABSLD: begin
            dTake   = 1'b1;
            dTarget = sImm;
            dLink   = (fA == BR_ABSLD);
            dDelay  = fA[4];
          end
          BR_BREAK: begin
            dTake   = 1'b1;
            dTarget = sImm;
            dLink   = 1'b1;
            dSetBip = 1'b1;
          end
          BR_BARRIER: begin
            // Low field must hold the fixed barrier pattern
            dBar = (imm == BAR_LOW);
            dIll = (imm != BAR_LOW);
          end
          default: dIll = 1'b1;
        endcase
      end
      OP_RETURN: begin
        dTarget = opA + sImm;
        dDelay  = 1'b1;
        unique case (fD)
          RET_SUB: dTake = 1'b1;
          RET_INT: begin
            dTake  = 1'b1;
            dSetIe = 1'b1;
          end
          RET_BRK: begin
            dTake   = 1'b1;
            dClrBip = 1'b1;
          end
          RET_EXC: begin
            dTake = 1'b1;
            dRte  = 1'b1;
          end
          default: dIll = 1'b1;
        endcase
      end
      OP_LBU, OP_LHU, OP_LW, OP_SB, OP_SH, OP_SW: begin
        dMem  = 1'b1;
        dLoad = !op[2];
        dSz   = op[1:0];
        unique case (fn)
          FN_NORM, FN_ALT: dAddr = opA + opB;
          FN_EXT: begin
            dExt  = 1'b1;
            dAddr = opB;
          end
          FN_RESV: begin
            // Only word load and word store have a reserving form
            dResv = (op == OP_LW);
            dCond = (op == OP_SW);
            dIll  = (op != OP_LW) && (op != OP_SW);
            dAddr = {dAddr[31:2], 2'h0};
          end
          default: dIll = 1'b1;
        endcase
      end
      OP_LBUI, OP_LHUI, OP_LWI, OP_SBI, OP_SHI, OP_SWI: begin
        dMem  = 1'b1;
        dLoad = !op[2];
        dSz   = op[1:0];
        dAddr = opA + sImm;
      end
      default: dIll = 1'b1;
    endcase
    // Store item copied into every lane
    unique case (dSz)
      SZ_BYTE: dWdata = {4{opD[7:0]}};
      SZ_HALF: dWdata = {2{opD[15:0]}};
      default: dWdata = opD;
    endcase
    // Plain forms fault when misaligned
    dFault = dMem && !dIll && ((dSz == SZ_HALF && dAddr[0]) ||
                               (dSz == SZ_WORD && dAddr[1:0] != 2'h0));
  end

  logic accept;
  logic doMem;
  logic skipCond;
  assign accept   = ce && instrValid && (state_r == S_IDLE);
  // A conditional store with no reservation touches no memory
  assign skipCond = dCond && !resv_r;
  assign doMem    = dMem && !dIll && !dFault && !skipCond;

  // Sequencer: idle, waiting on memory, or holding at a barrier
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
    end else if (ce) begin
      unique case (state_r)
        S_IDLE: begin
          if (accept && doMem) begin
            state_r <= S_MEM;
          end else if (accept && dBar) begin
            state_r <= S_BAR;
          end
        end
        S_MEM: begin
          if (memAck) begin
            state_r <= S_IDLE;
          end
        end
        S_BAR: begin
          // Hold until the bus is quiet
          if (memDrained) begin
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Prefix capture; dropped by whatever instruction follows it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prefValid_r <= 1'b0;
      prefHi_r    <= 16'h0000;
      irqHold     <= 1'b0;
    end else if (ce && accept) begin
      prefValid_r <= dPrefix;
      irqHold     <= dPrefix;
      if (dPrefix) begin
        prefHi_r <= imm;
      end
    end
  end

  // Memory bus request, held until acknowledged
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      memReq     <= 1'b0;
      memWe      <= 1'b0;
      memAddr    <= 32'h0000_0000;
      memAddrHi  <= 32'h0000_0000;
      memWdata   <= 32'h0000_0000;
      memBe      <= 4'h0;
      ldPend_r   <= 1'b0;
      resvPend_r <= 1'b0;
      szPend_r   <= SZ_WORD;
    end else if (ce) begin
      if (accept && doMem) begin
        memReq     <= 1'b1;
        memWe      <= !dLoad;
        memAddr    <= dAddr;
        memAddrHi  <= dExt ? opA : 32'h0000_0000;
        memWdata   <= dWdata;
        memBe      <= laneBe(dSz, dAddr[1:0]);
        ldPend_r   <= dLoad;
        resvPend_r <= dResv;
        szPend_r   <= dSz;
      end else if (state_r == S_MEM && memAck) begin
        memReq <= 1'b0;
        memWe  <= 1'b0;
      end
    end
  end

  // Retirement: next program counter, link and load results
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done           <= 1'b0;
      busy           <= 1'b0;
      pcNext         <= 32'h0000_0000;
      taken          <= 1'b0;
      delaySlot      <= 1'b0;
      rdWe           <= 1'b0;
      rdIdx          <= 5'h00;
      rdData         <= 32'h0000_0000;
      illegal        <= 1'b0;
      unalignedFault <= 1'b0;
    end else if (ce) begin
      done           <= 1'b0;
      rdWe           <= 1'b0;
      illegal        <= 1'b0;
      unalignedFault <= 1'b0;
      if (accept) begin
        taken     <= dTake && !dIll;
        delaySlot <= dDelay && !dIll;
        pcNext    <= (dTake && !dIll) ? dTarget : pc + PC_STEP;
        rdIdx     <= fD;
        rdData    <= pc;
        if (doMem || dBar) begin
          busy <= 1'b1;
        end else begin
          done           <= 1'b1;
          rdWe           <= dLink && !dIll;
          illegal        <= dIll;
          unalignedFault <= dFault;
        end
      end else if ((state_r == S_MEM && memAck) || (state_r == S_BAR && memDrained)) begin
        busy <= 1'b0;
        done <= 1'b1;
        if (state_r == S_MEM && ldPend_r) begin
          rdWe   <= 1'b1;
          rdData <= loadData(szPend_r, memAddr[1:0], memRdata);
        end
      end
    end
  end

  // Status bits; the last assignment wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ie_r    <= RST_IE;
      carry_r <= 1'b0;
      bip_r   <= 1'b0;
      ee_r    <= RST_EE;
      eip_r   <= 1'b0;
      cause_r <= RST_CAUSE;
    end else if (ce) begin
      if (regWe && regAddr == OFF_STATUS) begin
        ie_r    <= regWdata[BIT_IE];
        carry_r <= regWdata[BIT_CARRY];
        bip_r   <= regWdata[BIT_BIP];
        ee_r    <= regWdata[BIT_EE];
        eip_r   <= regWdata[BIT_EIP];
      end
      if (regWe && regAddr == OFF_CAUSE) begin
        cause_r <= regWdata;
      end
      if (irqTaken) begin
        ie_r <= 1'b0;
      end
      if (brkTaken) begin
        bip_r <= 1'b1;
      end
      if (excTaken) begin
        ee_r    <= 1'b0;
        eip_r   <= 1'b1;
        cause_r <= excCause;
      end
      if (accept && !dIll) begin
        if (dSetIe) begin
          ie_r <= 1'b1;
        end
        if (dSetBip) begin
          bip_r <= 1'b1;
        end
        if (dClrBip) begin
          bip_r <= 1'b0;
        end
        if (dRte) begin
          ee_r    <= 1'b1;
          eip_r   <= 1'b0;
          cause_r <= RST_CAUSE;
        end
        if (dCond) begin
          // Carry reports the outcome of the conditional store
          carry_r <= !resv_r;
        end
      end
    end
  end

  // Reservation flag only; no word address is kept or compared
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resv_r <= 1'b0;
    end else if (ce) begin
      if (state_r == S_MEM && memAck && resvPend_r) begin
        resv_r <= 1'b1;
      end
      if (accept && dCond) begin
        resv_r <= 1'b0;
      end
      // Disruptions come last so they win over a completing reserve
      if (irqTaken || excTaken || brkTaken || (accept && dSetBip)) begin
        resv_r <= 1'b0;
      end
    end
  end

  // Read port: data one cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h0000_0000;
    end else if (ce) begin
      regRdata <= 32'h0000_0000;
      if (regRe) begin
        unique case (regAddr)
          OFF_STATUS: begin
            regRdata[BIT_IE]    <= ie_r;
            regRdata[BIT_CARRY] <= carry_r;
            regRdata[BIT_BIP]   <= bip_r;
            regRdata[BIT_EE]    <= ee_r;
            regRdata[BIT_EIP]   <= eip_r;
          end
          OFF_CAUSE: regRdata <= cause_r;
          OFF_STATE: regRdata <= {26'h0000000, irqHold, prefValid_r,
                                  (state_r == S_BAR), (state_r == S_MEM), busy, resv_r};
          default:   regRdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Status outputs, registered copies
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interruptEnable     <= RST_IE;
      breakInProgress     <= 1'b0;
      exceptionEnable     <= RST_EE;
      exceptionInProgress <= 1'b0;
      reservation         <= 1'b0;
    end else if (ce) begin
      interruptEnable     <= ie_r;
      breakInProgress     <= bip_r;
      exceptionEnable     <= ee_r;
      exceptionInProgress <= eip_r;
      reservation         <= resv_r;
    end
  end

endmodule
`default_nettype wire

// [rtl/brls_pkg.sv]
// Package of constants for the branch, return, load and store execute block
package brls_pkg;
  // Major opcodes
  localparam logic [5:0] OP_PREFIX  = 6'h2c;
  localparam logic [5:0] OP_RETURN  = 6'h2d;
  localparam logic [5:0] OP_BRIMM   = 6'h2e;
  localparam logic [5:0] OP_BCCIMM  = 6'h2f;
  localparam logic [5:0] OP_LBU     = 6'h30;
  localparam logic [5:0] OP_LHU     = 6'h31;
  localparam logic [5:0] OP_LW      = 6'h32;
  localparam logic [5:0] OP_SB      = 6'h34;
  localparam logic [5:0] OP_SH      = 6'h35;
  localparam logic [5:0] OP_SW      = 6'h36;
  localparam logic [5:0] OP_LBUI    = 6'h38;
  localparam logic [5:0] OP_LHUI    = 6'h39;
  localparam logic [5:0] OP_LWI     = 6'h3a;
  localparam logic [5:0] OP_SBI     = 6'h3c;
  localparam logic [5:0] OP_SHI     = 6'h3d;
  localparam logic [5:0] OP_SWI     = 6'h3e;
  // Five-bit selector values of the immediate branch opcode
  localparam logic [4:0] BR_REL     = 5'h00;
  localparam logic [4:0] BR_RELD    = 5'h10;
  localparam logic [4:0] BR_RELLD   = 5'h14;
  localparam logic [4:0] BR_ABS     = 5'h08;
  localparam logic [4:0] BR_ABSD    = 5'h18;
  localparam logic [4:0] BR_ABSLD   = 5'h1c;
  localparam logic [4:0] BR_BREAK   = 5'h0c;
  localparam logic [4:0] BR_BARRIER = 5'h02;
  localparam logic [15:0] BAR_LOW   = 16'h0004;
  // Return selectors
  localparam logic [4:0] RET_SUB    = 5'h10;
  localparam logic [4:0] RET_INT    = 5'h11;
  localparam logic [4:0] RET_BRK    = 5'h12;
  localparam logic [4:0] RET_EXC    = 5'h14;
  localparam logic [4:0] PREFIX_SEL = 5'h00;
  // Conditions of the conditional branch
  localparam logic [2:0] CC_EQ      = 3'h0;
  localparam logic [2:0] CC_NE      = 3'h1;
  localparam logic [2:0] CC_LT      = 3'h2;
  localparam logic [2:0] CC_LE      = 3'h3;
  localparam logic [2:0] CC_GT      = 3'h4;
  localparam logic [2:0] CC_GE      = 3'h5;
  // Function field of register-addressed memory forms
  localparam logic [10:0] FN_NORM   = 11'h000;
  localparam logic [10:0] FN_ALT    = 11'h200;
  localparam logic [10:0] FN_EXT    = 11'h080;
  localparam logic [10:0] FN_RESV   = 11'h400;
  // Access sizes
  localparam logic [1:0] SZ_BYTE    = 2'h0;
  localparam logic [1:0] SZ_HALF    = 2'h1;
  localparam logic [1:0] SZ_WORD    = 2'h2;
  // Register offsets and machine status bit positions
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CAUSE  = 8'h04;
  localparam logic [7:0] OFF_STATE  = 8'h08;
  localparam int BIT_IE             = 1;
  localparam int BIT_CARRY          = 2;
  localparam int BIT_BIP            = 3;
  localparam int BIT_EE             = 8;
  localparam int BIT_EIP            = 9;
  localparam logic RST_IE           = 1'b0;
  localparam logic RST_EE           = 1'b0;
  localparam logic [31:0] RST_CAUSE = 32'h0000_0000;
  localparam logic [31:0] PC_STEP   = 32'h0000_0004;
endpackage

// [testbench/branch_return_load_store_decode_tb.sv]
// Directed bench for the branch, return, load and store execute block
`timescale 1ns/1ps
`default_nettype none
module branch_return_load_store_decode_tb;
  import brls_pkg::*;
  logic mclk, rst, ce, instrValid, busy, done, taken, delaySlot, rdWe, illegal;
  logic unalignedFault, irqHold, irqTaken, excTaken, brkTaken, memReq, memWe, memAck;
  logic memDrained, regWe, regRe, interruptEnable, breakInProgress, exceptionEnable;
  logic exceptionInProgress, reservation, stall;
  logic [31:0] instr, pc, opA, opB, opD, pcNext, rdData, excCause, memAddr, memAddrHi;
  logic [31:0] memWdata, memRdata, regWdata, regRdata, lastAddr, lastHi, rv, a;
  logic [4:0]  rdIdx;
  logic [3:0]  memBe;
  logic [7:0]  regAddr;
  logic [1:0]  lat;
  int          mismatches, n_checks, waited;
  logic [4:0]  sel [7] = '{BR_REL, BR_RELD, BR_RELLD, BR_ABS, BR_ABSD, BR_ABSLD, BR_BREAK};
  logic [4:0]  ret [4] = '{RET_SUB, RET_INT, RET_BRK, RET_EXC};
  logic [5:0]  lop [3] = '{OP_LBU, OP_LHU, OP_LW};
  logic [10:0] fns [3] = '{FN_NORM, FN_ALT, FN_EXT};
  logic [31:0] lad [3] = '{32'h21, 32'h22, 32'h20};
  logic [31:0] lex [3] = '{32'hab, 32'hbeef, 32'h00ab_beef};
  brls_exec i_brls_exec (.*);
  brls_mem_model i_brls_mem_model (.*);
  // Last acked address
  always @(posedge mclk) if (memReq && memAck) begin
    lastAddr <= memAddr;
    lastHi   <= memAddrHi;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // Issue one instruction, wait boundedly for retirement
  task automatic run(input logic [31:0] i, input logic [31:0] x, input logic [31:0] y,
                     input logic [31:0] d);
    @(posedge mclk);
    instr      <= i;
    opA        <= x;
    opB        <= y;
    opD        <= d;
    instrValid <= 1'b1;
    @(posedge mclk);
    instrValid <= 1'b0;
    waited = 0;
    #1;
    while (done !== 1'b1 && waited < 40) begin
      @(posedge mclk);
      #1 waited++;
    end
    if (waited >= 40) mismatches++;
  endtask
  task automatic reg_io(input logic we, input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk);
    regAddr  <= ad;
    regWdata <= d;
    regWe    <= we;
    regRe    <= !we;
    @(posedge mclk);
    regWe <= 1'b0;
    regRe <= 1'b0;
    #1 rv = regRdata;
  endtask
  // Status copies trail the internal state by a cycle
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  function automatic logic cond(input logic [2:0] c, input logic [31:0] v);
    case (c)
      CC_EQ: return v == 0;
      CC_NE: return v != 0;
      CC_LT: return $signed(v) < 0;
      CC_LE: return $signed(v) <= 0;
      CC_GT: return $signed(v) > 0;
      default: return $signed(v) >= 0;
    endcase
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    ce  = 1'b1;
    pc  = 32'h0000_1000;
    {instrValid, irqTaken, excTaken, brkTaken, regWe, regRe, stall} = '0;
    {instr, opA, opB, opD, excCause, regWdata, regAddr, lat} = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    // Each condition on zero, plus, minus
    for (int c = 0; c < 6; c++) for (int v = 0; v < 3; v++) begin
      a = (v == 0) ? 32'h0 : (v == 1) ? 32'h7 : 32'h8000_0000;
      run({OP_BCCIMM, c[0], 1'b0, c[2:0], 5'h3, 16'hfff0}, a, 0, 0);
      chkb(taken, cond(c[2:0], a));
      chkb(delaySlot, c[0]);
      chk(pcNext, cond(c[2:0], a) ? pc - 32'h10 : pc + PC_STEP);
    end
    $display("cond done");
    foreach (sel[k]) begin
      run({OP_BRIMM, 5'h9, sel[k], 16'h8020}, 0, 0, 0);
      chk(pcNext, (sel[k][3] ? 32'h0 : pc) + 32'hffff_8020);
      chkb(rdWe, sel[k][2]);
      if (sel[k][2]) chk(rdData, pc);
    end
    settle();
    chkb(breakInProgress, 1'b1);
    @(posedge mclk);
    excTaken <= 1'b1;
    excCause <= 32'h0000_0021;
    @(posedge mclk);
    excTaken <= 1'b0;
    foreach (ret[k]) begin
      run({OP_RETURN, ret[k], 5'h1, 16'h8004}, 32'h2000, 0, 0);
      chk(pcNext, 32'hffff_a004);
    end
    settle();
    chkb(interruptEnable, 1'b1);
    chkb(breakInProgress, 1'b0);
    chkb(exceptionEnable, 1'b1);
    chkb(exceptionInProgress, 1'b0);
    reg_io(1'b0, OFF_CAUSE, 0);
    chk(rv, 32'h0);
    // Barrier held back by an undrained bus
    stall <= 1'b1;
    fork
      run({OP_BRIMM, 5'h0, BR_BARRIER, BAR_LOW}, 0, 0, 0);
      begin
        repeat (6) @(posedge mclk);
        stall <= 1'b0;
      end
    join
    chkb(waited == 5, 1'b1);
    chk(pcNext, pc + PC_STEP);
    $display("jumps done");
    lat <= 2'h2;
    run({OP_SWI, 5'h4, 5'h1, 16'h4}, 32'h10, 0, 32'h1122_3344);
    chk(lastAddr, 32'h14);
    run({OP_LWI, 5'h4, 5'h1, 16'h4}, 32'h10, 0, 0);
    chk(rdData, 32'h1122_3344);
    run({OP_SWI, 5'h4, 5'h1, 16'h0}, 32'h20, 0, 0);
    run({OP_SBI, 5'h4, 5'h1, 16'h1}, 32'h20, 0, 32'hab);
    run({OP_SHI, 5'h4, 5'h1, 16'h2}, 32'h20, 0, 32'hbeef);
    run({OP_LBUI, 5'h4, 5'h1, 16'h1}, 32'h20, 0, 0);
    chk(rdData, 32'hab);
    run({OP_LHUI, 5'h4, 5'h1, 16'h2}, 32'h20, 0, 0);
    chk(rdData, 32'hbeef);
    lat <= 2'h0;
    for (int j = 0; j < 3; j++) for (int f = 0; f < 3; f++) begin
      a = (f == 2) ? 32'h5 : 32'h0;
      run({lop[j], 5'h4, 5'h1, 5'h2, fns[f]}, a, lad[j], 0);
      chk(rdData, lex[j]);
      chk(lastHi, a);
    end
    run({OP_LW, 5'h4, 5'h1, 5'h2, FN_RESV}, 32'h22, 0, 0);
    chkb(unalignedFault, 1'b0);
    chk(lastAddr, 32'h20);
    settle();
    chkb(reservation, 1'b1);
    for (int r = 0; r < 2; r++) begin
      run({OP_SW, 5'h4, 5'h1, 5'h2, FN_RESV}, 32'h30, 0, 32'h77 + 32'(r));
      settle();
      chkb(reservation, 1'b0);
      run({OP_LWI, 5'h4, 5'h1, 16'h0}, 32'h30, 0, 0);
      chk(rdData, 32'h77);
    end
    run({OP_LW, 5'h4, 5'h1, 5'h2, FN_RESV}, 32'h20, 0, 0);
    irqTaken <= 1'b1;
    @(posedge mclk);
    irqTaken <= 1'b0;
    settle();
    chkb(reservation, 1'b0);
    $display("memory done");
    run({OP_PREFIX, 10'h0, 16'h1234}, 0, 0, 0);
    chkb(irqHold, 1'b1);
    run({OP_BRIMM, 5'h0, BR_ABS, 16'h5678}, 0, 0, 0);
    chk(pcNext, 32'h1234_5678);
    // Unmapped and read-only read zero
    reg_io(1'b1, 8'h40, 32'hffff_ffff);
    reg_io(1'b0, 8'h40, 0);
    chk(rv, 32'h0);
    reg_io(1'b1, OFF_STATE, 32'hffff_ffff);
    reg_io(1'b0, OFF_STATE, 0);
    chk(rv, 32'h0);
    $display("prefix done");
    end_of_test();
  end
endmodule
`default_nettype wire

// [testbench/brls_exec_asserts.sv]
// Port-level checks on the execute block
`timescale 1ns/1ps
`default_nettype none
module brls_exec_asserts
  import brls_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        instrValid,
  input wire logic [31:0] instr,
  input wire logic [31:0] opA,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [31:0] pcNext,
  input wire logic        taken,
  input wire logic        rdWe,
  input wire logic        unalignedFault,
  input wire logic        irqHold,
  input wire logic        memReq,
  input wire logic        memWe,
  input wire logic [31:0] memAddr,
  input wire logic        memAck,
  input wire logic        interruptEnable,
  input wire logic        breakInProgress
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Instruction taken by an idle unit
  sequence s_acc;
    ce && instrValid && !busy;
  endsequence
  sequence s_imm(logic [4:0] sel);
    s_acc ##0 instr[31:26] == OP_BRIMM && instr[20:16] == sel;
  endsequence
  sequence s_resv;
    s_acc ##0 (instr[31:26] == OP_LW || instr[31:26] == OP_SW) && instr[10:0] == FN_RESV;
  endsequence
  a_bus_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
    && $stable(memWe)) else $error("request moved");
  a_ack_retire: assert property (memReq && memAck |=> done && !memReq)
    else $error("no retire");
  a_link_pulse: assert property (rdWe |-> done)
    else $error("stray link write");
  a_abs_target: assert property (s_imm(BR_ABS) ##0 !irqHold |=> done
    && pcNext == {{16{$past(instr[15])}}, $past(instr[15:0])}) else $error("bad target");
  a_beq_taken: assert property (s_acc ##0 instr[31:26] == OP_BCCIMM
    && instr[23:21] == CC_EQ |=> taken == ($past(opA) == 32'h0)) else $error("zero test wrong");
  a_int_return: assert property (s_acc ##0 instr[31:26] == OP_RETURN
    && instr[25:21] == RET_INT |-> ##[1:3] interruptEnable) else $error("no enable");
  a_break_sets: assert property (s_imm(BR_BREAK) |-> ##[1:3] breakInProgress)
    else $error("break flag not set");
  a_bar_wait: assert property (s_imm(BR_BARRIER) |=> !done)
    else $error("early barrier");
  a_resv_nofault: assert property (s_resv |-> ##[1:40] done ##0 !unalignedFault)
    else $error("reserve faulted");
endmodule
bind brls_exec brls_exec_asserts i_chk (.mclk(mclk), .rst(rst), .ce(ce),
  .instrValid(instrValid), .instr(instr), .opA(opA), .busy(busy), .done(done),
  .pcNext(pcNext), .taken(taken), .rdWe(rdWe), .unalignedFault(unalignedFault),
  .irqHold(irqHold), .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memAck(memAck),
  .interruptEnable(interruptEnable), .breakInProgress(breakInProgress));
`default_nettype wire

// [testbench/brls_mem_model.sv]
// Behavioural data memory on the far side of the execute block
`timescale 1ns/1ps
`default_nettype none
module brls_mem_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        stall,
  input  wire logic [1:0]  lat,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [31:0] memAddr,
  input  wire logic [3:0]  memBe,
  input  wire logic [31:0] memWdata,
  output logic             memAck,
  output logic [31:0]      memRdata,
  output logic             memDrained
);
  logic [31:0] mem [16]; // Sixteen words, picked by address bits 5:2
  logic [1:0]  cnt;      // Wait states spent on the current access
  wire logic   go = memReq && !memAck && cnt == lat;
  // Ack after lat wait states; only enabled lanes are written
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      memAck <= 1'b0;
      cnt    <= 2'h0;
      for (int i = 0; i < 16; i++) mem[i] <= 32'h5a00_0000 + 32'(i);
    end else begin
      memAck <= go;
      cnt    <= (memReq && !memAck && !go) ? cnt + 2'h1 : 2'h0;
      for (int i = 0; i < 4; i++)
        if (go && memWe && memBe[i]) mem[memAddr[5:2]][i*8+:8] <= memWdata[i*8+:8];
    end
  end
  // Junk outside ack exposes stale reads
  assign memRdata   = memAck ? mem[memAddr[5:2]] : ~memAddr;
  // Stall holds a barrier back
  assign memDrained = !memReq && !stall;
endmodule
`default_nettype wire
